/* src/rfecr_route_unit.sv */
`timescale 1ns/1ns
`default_nettype none

// Function
// - A route of zero up to eight drops is accepted for sending.
// - Each drop is sent as two ASCII hex digits, drops in order.
// - The route comes whole from above or from the destination table.
// - A received route is reversible only if 0 to 16 bytes and even.
// - A non-reversible route is flagged to the link layer for a NAK.
// - Command route data is valid only if not one drop and all hex chars.
// - Invalid command route data yields error code 29, no execution.
// - A reply carries the command route with its drop order reversed.
// - A received reply gets the reversibility check only.
module rfecr_route_unit
  import rfecr_pkg::*;
#(
  parameter int MAX_DROPS = RFECR_MAX_DROPS
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cmdStart,
  input wire logic cmdUseTable,
  input wire logic [3:0] cmdDropCount,
  input wire logic [63:0] cmdDrops,
  input wire logic [RFECR_DEST_WIDTH-1:0] cmdDestId,
  input wire logic replyStart,
  input wire logic txReady,
  output logic [7:0] txByte,
  output logic txValid,
  output logic txLast,
  output logic txDone,
  output logic busy,
  input wire logic [7:0] rxByte,
  input wire logic rxValid,
  input wire logic rxEnd,
  input wire logic rxIsCommand,
  output logic rxDone,
  output logic rxNotReversible,
  output logic rxRouteInvalid,
  output logic [7:0] rxErrorCode,
  output logic replyReady
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (MAX_DROPS < 1 || MAX_DROPS > RFECR_MAX_DROPS)
  begin : gBadDrops
    $error("MAX_DROPS must lie between 1 and 8.");
  end

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Turns one nibble into its ASCII hex character.
  function automatic logic [7:0] hexChar(input logic [3:0] nib);
    if (nib < RFECR_NIBBLE_TEN)
    begin
      hexChar = RFECR_DIGIT_LO + {4'h0, nib};
    end
    else
    begin
      hexChar = RFECR_LETTER_LO + {4'h0, nib - RFECR_NIBBLE_TEN};
    end
  endfunction

  // Tells whether a byte is one of the legal route characters.
  function automatic logic isRouteChar(input logic [7:0] b);
    isRouteChar = (b >= RFECR_DIGIT_LO && b <= RFECR_DIGIT_HI) ||
                  (b >= RFECR_LETTER_LO && b <= RFECR_LETTER_HI);
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  rfecr_regs_t r_reg;
  rfecr_regs_t r_next;

  localparam logic [3:0] MAX_DROPS_L = 4'(MAX_DROPS);

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // Builds routes for sending and checks routes as they arrive.
  always_comb
  begin
    logic load;
    logic [15:0][7:0] loadChars;
    logic [4:0] loadLen;
    logic [3:0] dropCnt;
    logic [63:0] drops;
    logic [3:0] nDrops;
    logic [3:0] srcDrop;
    logic [4:0] len;
    logic rev;
    logic invalid;
    load = 1'b0;
    loadChars = '0;
    loadLen = 5'h00;
    dropCnt = 4'h0;
    drops = 64'h0;
    nDrops = 4'h0;
    srcDrop = 4'h0;
    len = 5'h00;
    rev = 1'b0;
    invalid = 1'b0;
    r_next = r_reg;
    r_next.txDone = 1'b0;
    r_next.rxDone = 1'b0;

    // Command route: given whole or looked up, then hex encoded.
    if (cmdUseTable)
    begin
      dropCnt = RFECR_TABLE_COUNTS[cmdDestId];
      drops = RFECR_TABLE_DROPS[cmdDestId];
    end
    else
    begin
      dropCnt = cmdDropCount;
      drops = cmdDrops;
    end
    if (dropCnt > MAX_DROPS_L)
    begin
      dropCnt = MAX_DROPS_L;
    end

    case (r_reg.state)
      RFECR_ST_IDLE:
      begin
        if (cmdStart)
        begin
          load = 1'b1;
          loadLen = {dropCnt, 1'b0};
          for (int i = 0; i < RFECR_MAX_DROPS; i++)
          begin
            if (4'(i) < dropCnt)
            begin
              loadChars[2*i] = hexChar(drops[8*i+4 +: 4]);
              loadChars[2*i+1] = hexChar(drops[8*i +: 4]);
            end
          end
        end
        else if (replyStart && r_reg.rxRevOk)
        begin
          // Whole drop pairs swap ends; characters keep their order.
          load = 1'b1;
          loadLen = r_reg.rxRouteLen;
          nDrops = r_reg.rxRouteLen[4:1];
          for (int i = 0; i < RFECR_MAX_DROPS; i++)
          begin
            if (4'(i) < nDrops)
            begin
              srcDrop = nDrops - 4'h1 - 4'(i);
              loadChars[2*i] = r_reg.rxBuf[{srcDrop, 1'b0}];
              loadChars[2*i+1] = r_reg.rxBuf[{srcDrop, 1'b1}];
            end
          end
        end
        if (load)
        begin
          r_next.txChars = loadChars;
          r_next.txLen = loadLen;
          if (loadLen == 5'h00)
          begin
            r_next.txDone = 1'b1;
          end
          else
          begin
            r_next.state = RFECR_ST_SEND;
            r_next.busy = 1'b1;
            r_next.txByte = loadChars[0];
            r_next.txValid = 1'b1;
            // A non-empty route holds at least two chars, so never last.
            r_next.txLast = 1'b0;
            r_next.txIdx = 5'h01;
          end
        end
      end
      RFECR_ST_SEND:
      begin
        // Each byte stands until the link takes it.
        if (txReady)
        begin
          if (r_reg.txLast)
          begin
            r_next.state = RFECR_ST_IDLE;
            r_next.busy = 1'b0;
            r_next.txValid = 1'b0;
            r_next.txLast = 1'b0;
            r_next.txDone = 1'b1;
          end
          else
          begin
            r_next.txByte = r_reg.txChars[r_reg.txIdx[3:0]];
            r_next.txLast = (r_reg.txIdx + 5'h01 == r_reg.txLen);
            r_next.txIdx = r_reg.txIdx + 5'h01;
          end
        end
      end
      default:
      begin
        r_next = RFECR_RESET;
      end
    endcase

    // Received route bytes are stored and counted; the count saturates.
    if (rxValid)
    begin
      if (r_reg.rxLen < RFECR_MAX_ROUTE_BYTES)
      begin
        r_next.rxBuf[r_reg.rxLen[3:0]] = rxByte;
      end
      if (!isRouteChar(rxByte))
      begin
        r_next.rxBadChar = 1'b1;
      end
      if (r_reg.rxLen < RFECR_LEN_SATURATE)
      begin
        r_next.rxLen = r_reg.rxLen + 5'h01;
      end
    end

    // End of the route field: judge it and rearm for the next one.
    if (rxEnd)
    begin
      len = r_reg.rxLen;
      rev = (len <= RFECR_MAX_ROUTE_BYTES) && !len[0];
      invalid = rxIsCommand &&
                ((len == RFECR_ONE_DROP_BYTES) || r_reg.rxBadChar);
      r_next.rxDone = 1'b1;
      r_next.rxNotReversible = !rev;
      r_next.rxRouteInvalid = invalid;
      r_next.rxErrorCode = invalid ? RFECR_ERR_ILLEGAL_ROUTE
                                   : RFECR_ERR_NONE;
      r_next.rxRevOk = rev;
      r_next.rxRouteLen = len;
      r_next.rxLen = 5'h00;
      r_next.rxBadChar = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------

  // Holds the whole state; reset is synchronous.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      r_reg <= RFECR_RESET;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // Every output is a field of the state register.
  assign txByte = r_reg.txByte;
  assign txValid = r_reg.txValid;
  assign txLast = r_reg.txLast;
  assign txDone = r_reg.txDone;
  assign busy = r_reg.busy;
  assign rxDone = r_reg.rxDone;
  assign rxNotReversible = r_reg.rxNotReversible;
  assign rxRouteInvalid = r_reg.rxRouteInvalid;
  assign rxErrorCode = r_reg.rxErrorCode;
  assign replyReady = r_reg.rxRevOk;

endmodule

`default_nettype wire

/* src/rfecr_pkg.sv */
package rfecr_pkg;

  // ----------------------------------------------------------------------
  // Route limits and character ranges
  // ----------------------------------------------------------------------
  localparam int RFECR_MAX_DROPS = 8;
  localparam logic [4:0] RFECR_MAX_ROUTE_BYTES = 5'h10;
  localparam logic [4:0] RFECR_LEN_SATURATE = 5'h11;
  localparam logic [4:0] RFECR_ONE_DROP_BYTES = 5'h02;
  localparam logic [7:0] RFECR_DIGIT_LO = 8'h30;
  localparam logic [7:0] RFECR_DIGIT_HI = 8'h39;
  localparam logic [7:0] RFECR_LETTER_LO = 8'h41;
  localparam logic [7:0] RFECR_LETTER_HI = 8'h46;
  localparam logic [3:0] RFECR_NIBBLE_TEN = 4'hA;

  // Error code for an illegal route, decimal 29.
  localparam logic [7:0] RFECR_ERR_ILLEGAL_ROUTE = 8'h1D;
  localparam logic [7:0] RFECR_ERR_NONE = 8'h00;

  // ----------------------------------------------------------------------
  // Predefined destination table
  // ----------------------------------------------------------------------
  localparam int RFECR_DEST_WIDTH = 2;
  localparam int RFECR_TABLE_SIZE = 4;
  // Drop 0 sits in the low byte of each entry.
  localparam logic [RFECR_TABLE_SIZE-1:0][63:0] RFECR_TABLE_DROPS = {
    64'h0000_0000_0003_0201,
    64'h0000_0000_0000_0A05,
    64'h0000_0000_0000_0010,
    64'h0000_0000_0000_0000
  };
  localparam logic [RFECR_TABLE_SIZE-1:0][3:0] RFECR_TABLE_COUNTS = {
    4'h3,
    4'h2,
    4'h1,
    4'h0
  };

  // ----------------------------------------------------------------------
  // State encoding and register image
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RFECR_ST_IDLE = 2'b01,
    RFECR_ST_SEND = 2'b10
  } rfecr_state_t;

  typedef struct packed {
    rfecr_state_t state;
    logic busy;
    logic [15:0][7:0] txChars;
    logic [4:0] txLen;
    logic [4:0] txIdx;
    logic [7:0] txByte;
    logic txValid;
    logic txLast;
    logic txDone;
    logic [15:0][7:0] rxBuf;
    logic [4:0] rxLen;
    logic rxBadChar;
    logic [4:0] rxRouteLen;
    logic rxRevOk;
    logic rxDone;
    logic rxNotReversible;
    logic rxRouteInvalid;
    logic [7:0] rxErrorCode;
  } rfecr_regs_t;

  localparam rfecr_regs_t RFECR_RESET = '{
    state: RFECR_ST_IDLE,
    busy: 1'b0,
    txChars: '0,
    txLen: 5'h00,
    txIdx: 5'h00,
    txByte: 8'h00,
    txValid: 1'b0,
    txLast: 1'b0,
    txDone: 1'b0,
    rxBuf: '0,
    rxLen: 5'h00,
    rxBadChar: 1'b0,
    rxRouteLen: 5'h00,
    rxRevOk: 1'b0,
    rxDone: 1'b0,
    rxNotReversible: 1'b0,
    rxRouteInvalid: 1'b0,
    rxErrorCode: 8'h00
  };

endpackage

/* verif/rfecr_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------
// Route unit port checker
// ---------------------------------------------------------------------
module rfecr_monitor
  import rfecr_pkg::*;
#(
  parameter int MAX_DROPS = RFECR_MAX_DROPS
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic txReady,
  input wire logic cmdStart,
  input wire logic replyStart,
  input wire logic [7:0] txByte,
  input wire logic txValid,
  input wire logic txLast,
  input wire logic txDone,
  input wire logic busy,
  input wire logic rxEnd,
  input wire logic rxIsCommand,
  input wire logic rxDone,
  input wire logic rxNotReversible,
  input wire logic rxRouteInvalid,
  input wire logic [7:0] rxErrorCode,
  input wire logic replyReady
);
  // All checks run on the core clock and pause during reset.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Marks a transfer started as a command; only its chars must be hex.
  logic cmdSend;
  always_ff @(posedge core_clk)
  begin
    if (reset || (!busy && !cmdStart && replyStart))
      cmdSend <= 1'b0;
    else if (!busy && cmdStart)
      cmdSend <= 1'b1;
  end
  property p_done; rxEnd |=> rxDone; endproperty
  a_done: assert property (p_done) else $error("rxDone missing");
  property p_noDone; rxDone |-> $past(rxEnd); endproperty
  a_noDone: assert property (p_noDone) else $error("stray rxDone");
  property p_err;
    rxDone |-> rxErrorCode == (rxRouteInvalid ? 8'h1D : 8'h00);
  endproperty
  a_err: assert property (p_err) else $error("bad error code");
  property p_reply; rxDone && !$past(rxIsCommand) |-> !rxRouteInvalid;
  endproperty
  a_reply: assert property (p_reply) else $error("reply judged");
  property p_rev; rxDone |-> replyReady == !rxNotReversible; endproperty
  a_rev: assert property (p_rev) else $error("replyReady wrong");
  property p_hold;
    !rxDone |-> $stable(rxNotReversible) && $stable(rxRouteInvalid);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_stall;
    txValid && !txReady |=> txValid && $stable(txByte) && $stable(txLast);
  endproperty
  a_stall: assert property (p_stall) else $error("char dropped");
  property p_ascii;
    txValid && cmdSend |-> txByte inside {[8'h30:8'h39], [8'h41:8'h46]};
  endproperty
  a_ascii: assert property (p_ascii) else $error("not hex char");
  property p_end; txValid && txLast && txReady |=> txDone && !busy;
  endproperty
  a_end: assert property (p_end) else $error("no txDone");
  property p_busy; txValid |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("busy low");
  // Main scenarios reached.
  c_tx: cover property (txDone);
  c_inv: cover property (rxDone && rxRouteInvalid);
  c_nr: cover property (rxDone && rxNotReversible);
endmodule
bind rfecr_route_unit rfecr_monitor #(.MAX_DROPS(MAX_DROPS)) rfecr_monitor_inst
  (.core_clk, .reset, .txReady, .cmdStart, .replyStart, .txByte, .txValid,
  .txLast, .txDone, .busy, .rxEnd, .rxIsCommand, .rxDone, .rxNotReversible,
  .rxRouteInvalid, .rxErrorCode, .replyReady);
`default_nettype wire

/* verif/rfecr_link_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------
// Link framer model
// ---------------------------------------------------------------------
module rfecr_link_model
(
  input wire logic core_clk,
  input wire logic reset,
  output var logic txReady
);
  // Accepts route characters with random stalls, as a busy framer may.
  initial txReady = 1'b0;
  always @(posedge core_clk)
  begin
    #1;
    txReady <= reset ? 1'b0 : ($urandom % 3 != 0);
  end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------------
// Route unit testbench
// ---------------------------------------------------------------------
module tb_top
  import rfecr_pkg::*;
;
  logic core_clk, reset, cmdStart, cmdUseTable, replyStart, rxValid;
  logic rxEnd, rxIsCommand, txReady, txValid, txLast, txDone, busy;
  logic rxDone, rxNotReversible, rxRouteInvalid, replyReady;
  logic [3:0] cmdDropCount;
  logic [63:0] cmdDrops;
  logic [1:0] cmdDestId;
  logic [7:0] rxByte, txByte, rxErrorCode;
  logic [7:0] expQ[$], gotQ[$];
  int mismatches, comparisons;
  int cs[10][3] = '{'{0,1,0}, '{2,1,0}, '{3,1,0}, '{4,1,0}, '{16,1,0},
    '{18,1,0}, '{4,1,1}, '{2,0,0}, '{3,0,0}, '{6,0,1}};
  rfecr_route_unit rfecr_route_unit_inst (.core_clk, .reset, .cmdStart,
    .cmdUseTable, .cmdDropCount, .cmdDrops, .cmdDestId, .replyStart,
    .txReady, .txByte, .txValid, .txLast, .txDone, .busy, .rxByte, .rxValid,
    .rxEnd, .rxIsCommand, .rxDone, .rxNotReversible, .rxRouteInvalid,
    .rxErrorCode, .replyReady);
  rfecr_link_model rfecr_link_model_inst (.core_clk, .reset, .txReady);
  // Clock at 50 ns period.
  always #25 core_clk = ~core_clk;
  task tick;
    @(posedge core_clk);
    #1;
  endtask
  function automatic logic [7:0] hexc(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Gathers characters taken by the framer until txDone, then compares.
  task collect;
    int n;
    gotQ = {};
    for (n = 0; n < 300 && txDone !== 1'b1; n++)
    begin
      @(posedge core_clk);
      if (txValid === 1'b1 && txReady === 1'b1)
        gotQ.push_back(txByte);
    end
    if (n == 300)
    begin
      mismatches++;
      wrap_up;
    end
    chk(8'(gotQ.size()), 8'(expQ.size()));
    foreach (expQ[i])
      chk(gotQ[i], expQ[i]);
    tick;
  endtask
  task tx_cmd(input logic tab, input int cnt, input logic [63:0] d,
    input logic [1:0] id);
    expQ = {};
    if (tab)
    begin
      cnt = RFECR_TABLE_COUNTS[id];
      d = RFECR_TABLE_DROPS[id];
    end
    if (cnt > RFECR_MAX_DROPS)
      cnt = RFECR_MAX_DROPS;
    for (int k = 0; k < cnt; k++)
    begin
      expQ.push_back(hexc(d[8*k+4 +: 4]));
      expQ.push_back(hexc(d[8*k +: 4]));
    end
    {cmdUseTable, cmdDropCount, cmdDrops, cmdDestId} = {tab, 4'(cnt), d, id};
    cmdStart = 1'b1;
    tick;
    cmdStart = 1'b0;
    collect;
    $display("tx test done, %0d chars", expQ.size());
  endtask
  // Sends a route in, checks the verdict, then asks for the reply.
  task rx_route(input int n, input logic cmd, input logic bad);
    logic [7:0] q[$];
    logic nr;
    logic inv;
    q = {};
    for (int i = 0; i < n; i++)
      q.push_back(hexc(4'($urandom)));
    if (bad)
      q[1] = 8'h47;
    foreach (q[i])
    begin
      {rxValid, rxByte} = {1'b1, q[i]};
      tick;
    end
    {rxValid, rxByte, rxEnd, rxIsCommand} = {1'b0, ~rxByte, 1'b1, cmd};
    tick;
    rxEnd = 1'b0;
    nr = (n > 16) || (n % 2 == 1);
    inv = cmd && (n == 2 || bad);
    chk(rxDone, 1);
    chk(rxNotReversible, nr);
    chk(rxRouteInvalid, inv);
    chk(rxErrorCode, inv ? 8'h1D : 8'h00);
    chk(replyReady, !nr);
    replyStart = 1'b1;
    tick;
    replyStart = 1'b0;
    expQ = {};
    for (int k = n / 2 - 1; k >= 0; k--)
      expQ.push_back(q[2*k]);
    for (int k = n / 2 - 1; k >= 0 && !nr; k--)
      expQ.insert(expQ.size() - k, q[2*k+1]);
    if (!nr)
      collect;
    else
      chk({busy, txValid}, 0);
    $display("rx test done, %0d bytes", n);
  endtask
  // Main sequence.
  initial
  begin
    {core_clk, reset, cmdStart, cmdUseTable, replyStart, rxValid} = 6'h10;
    {rxEnd, rxIsCommand, cmdDropCount, cmdDrops, cmdDestId, rxByte} = '0;
    mismatches = 0;
    comparisons = 0;
    void'($urandom(32957));
    repeat (10) tick;
    reset = 1'b0;
    tx_cmd(0, 3, 64'h0000_0000_0051_0E64, 0);
    tx_cmd(0, 0, 64'h0, 0);
    tx_cmd(0, 1, {$urandom, $urandom}, 0);
    tx_cmd(0, 8, {$urandom, $urandom}, 0);
    tx_cmd(0, 12, {$urandom, $urandom}, 0);
    for (int i = 0; i < 4; i++)
      tx_cmd(1, 0, 64'h0, 2'(i));
    foreach (cs[i])
      rx_route(cs[i][0], cs[i][1], cs[i][2]);
    wrap_up;
  end
endmodule
`default_nettype wire
